//--- hdl/bctr_pkg.sv
package bctr_pkg;
  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] CTRL_OFFS      = 12'h000;
  localparam logic [11:0] STATUS_OFFS    = 12'h004;
  localparam logic [11:0] DELAY_OFFS     = 12'h008;
  localparam logic [11:0] COUNT_OFFS     = 12'h00C;
  localparam logic [11:0] RD_IDX_OFFS    = 12'h010;
  localparam logic [11:0] RD_ADDR_OFFS   = 12'h014;
  localparam logic [11:0] RD_DATA_OFFS   = 12'h018;
  localparam logic [11:0] RD_STATE_OFFS  = 12'h01C;
  localparam logic [11:0] RD_TIME_OFFS   = 12'h020;
  localparam logic [11:0] RD_NUM_OFFS    = 12'h024;
  localparam logic [11:0] FIFO_LVL_OFFS  = 12'h028;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_DELAY_EN_BIT = 0;
  localparam int STAT_FULL_BIT     = 0;
  localparam int STAT_STOPPED_BIT  = 1;
  localparam int STAT_TSOVF_BIT    = 2;
  localparam int STAT_RUN_BIT      = 3;
  localparam int STAT_DLYBUSY_BIT  = 4;

  // ****************************************************************
  // reset values and sizes
  // ****************************************************************
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] DELAY_RESET = 32'h0000_0000;
  localparam int TRACE_DEPTH_LOG2     = 22;
  localparam int FIFO_DEPTH           = 8;
  localparam int TIME_WIDTH           = 32;
  localparam logic [2:0] QUEUE_MAX    = 3'd4;

  // ****************************************************************
  // codes
  // ****************************************************************
  typedef enum logic [2:0] {
    BIU_NO_CHANGE,
    BIU_DMA,
    BIU_INTACK,
    BIU_INSTR_FETCH_BYTE,
    BIU_CPU_DATA_BYTE,
    BIU_INSTR_FETCH_WORD,
    BIU_CPU_DATA_WORD
  } bctr_biu_e;

  typedef enum logic [2:0] {
    CPU_NO_CHANGE,
    CPU_OPCODE_READ_BYTE,
    CPU_OPERAND_READ_BYTE,
    CPU_QUEUE_CLEAR,
    CPU_OPCODE_READ_WORD,
    CPU_OPERAND_READ_WORD
  } bctr_cpu_e;

  typedef enum logic [1:0] {
    DIR_NONE,
    DIR_READ,
    DIR_WRITE
  } bctr_dir_e;

  localparam int REC_WIDTH = 24 + 16 + 1 + 1 + 3 + 2 + 1 + 3 + 3 + 1 + 4 + 1;
endpackage

//--- hdl/bctr_fifo.sv
`timescale 1ns/100ps
module bctr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic             doWrite;
  logic             doRead;

  assign inReady  = (level != DEPTH[AW:0]);
  assign outValid = (level != '0);
  assign outData  = store[rdPtr];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  always_ff @(posedge clock)
  begin
    if (doWrite)
    begin
      store[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end
    else
    begin
      if (doWrite)
      begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRead)
      begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      if (doWrite && !doRead)
      begin
        level <= level + 1'b1;
      end
      else if (doRead && !doWrite)
      begin
        level <= level - 1'b1;
      end
    end
  end
endmodule

//--- hdl/bctr_recorder.sv
//
// Contract
// - newest stored cycle reads as index 0, older ones as -1, -2, ...
// - with delay on, stop cycle is 0 and delay cycles count +1, +2
// - each record stores bus width flag, 8-bit or 16-bit
// - each record stores upper byte enable; low means odd address
// - each record stores the bus-interface activity code
// - each record stores direction: read, write or none
// - each record stores active-low cycle-valid strobe
// - each record stores the CPU-side code
// - each record stores queue fill count, clamped to 0..4
// - ownership flag reads 0 while debugger owns bus; target suspended
// - a fired event stores its number in that cycle's record
// - outside trigger sampled as 1 when high, 0 when low
// - timestamp restarts at run start; records after overflow invalid
// - trace memory holds up to four mega cycles
// - when full, oldest records are overwritten first
//
`timescale 1ns/100ps
module bctr_recorder
  import bctr_pkg::*;
#(
  parameter int DEPTH_LOG2 = bctr_pkg::TRACE_DEPTH_LOG2,
  parameter int FIFO_DEP   = bctr_pkg::FIFO_DEPTH
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        programRun,
  input  wire logic        busCycle,
  input  wire logic [23:0] targetAddress,
  input  wire logic [15:0] targetData,
  input  wire logic        busWide,
  input  wire logic        upper_byte_enable_n,
  input  wire logic [2:0]  bus_interface_state,
  input  wire logic [1:0]  busDirection,
  input  wire logic        cycle_valid_n,
  input  wire logic [2:0]  cpuState,
  input  wire logic [2:0]  queue_fill_count,
  input  wire logic        debugger_bus_own,
  input  wire logic        eventFired,
  input  wire logic [3:0]  matched_point_id,
  input  wire logic        outside_trigger_level,
  input  wire logic        stopCondition,
  output logic             traceActive
);
  import bctr_pkg::*;

  localparam int RW = REC_WIDTH;
  localparam int CW = DEPTH_LOG2 + 1;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [RW+1:0] pinMeta;
  logic [RW+1:0] pinSync;
  logic [RW-1:0] rawRec;
  logic          runS;
  logic          cycS;
  logic          runLast;

  // ownership pin is active high on the pin; record stores it inverted
  assign rawRec = {
    targetAddress,
    targetData,
    busWide,
    upper_byte_enable_n,
    bus_interface_state,
    busDirection,
    cycle_valid_n,
    cpuState,
    queue_fill_count,
    ~debugger_bus_own,
    eventFired ? matched_point_id : 4'h0,
    outside_trigger_level
  };

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinMeta <= '0;
      pinSync <= '0;
    end
    else
    begin
      pinMeta <= {programRun, busCycle, rawRec};
      pinSync <= pinMeta;
    end
  end

  assign runS = pinSync[RW+1];
  assign cycS = pinSync[RW];

  logic stopMeta;
  logic stopSync;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stopMeta <= 1'b0;
      stopSync <= 1'b0;
    end
    else
    begin
      stopMeta <= stopCondition;
      stopSync <= stopMeta;
    end
  end

  // ****************************************************************
  // timestamp
  // ****************************************************************
  logic [TIME_WIDTH-1:0] stamp;
  logic                  stampOvf;
  logic                  runStart;
  logic [TIME_WIDTH-1:0] stampNow;
  logic                  ovfNow;

  // the first cycle of a run is time zero; the stale count is bypassed
  assign runStart = runS && !runLast;
  assign stampNow = runStart ? '0 : stamp;
  assign ovfNow   = stampOvf && !runStart;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stamp    <= '0;
      stampOvf <= 1'b0;
      runLast  <= 1'b0;
    end
    else
    begin
      runLast <= runS;
      if (runStart)
      begin
        stamp    <= TIME_WIDTH'(1);
        stampOvf <= 1'b0;
      end
      else if (runS)
      begin
        stamp <= stamp + 1'b1;
        if (&stamp)
        begin
          stampOvf <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // capture into fifo
  // ****************************************************************
  localparam int FW = RW + TIME_WIDTH + 1;
  logic [RW-1:0] clampRec;
  logic          capValid;
  logic          capReady;
  logic          delayEn;
  logic [31:0]   delayCount;
  logic [31:0]   delayLeft;
  logic          delayBusy;
  logic          stopped;
  logic          fifoValid;
  logic [FW-1:0] fifoData;
  logic [$clog2(FIFO_DEP):0] fifoLevel;

  always_comb
  begin
    clampRec = pinSync[RW-1:0];
    if (clampRec[8:6] > QUEUE_MAX)
    begin
      clampRec[8:6] = QUEUE_MAX;
    end
  end

  // a cycle is taken only when the fifo has room; the bus strobe is not held
  // back, so a cycle that arrives while the fifo is full is dropped
  assign capValid = runS && cycS && !stopped;

  bctr_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEP)
  ) u_fifo (
    .clock    (clock),
    .reset_n  (reset_n),
    .inValid  (capValid),
    .inReady  (capReady),
    .inData   ({ovfNow, stampNow, clampRec}),
    .outValid (fifoValid),
    .outReady (1'b1),
    .outData  (fifoData),
    .level    (fifoLevel)
  );

  // ****************************************************************
  // trace memory, circular
  // ****************************************************************
  logic [FW-1:0]         traceMem [2**DEPTH_LOG2];
  logic [DEPTH_LOG2-1:0] wrIdx;
  logic [CW-1:0]         stored;
  logic [DEPTH_LOG2-1:0] stopIdx;
  logic                  haveStop;

  always_ff @(posedge clock)
  begin
    if (fifoValid)
    begin
      traceMem[wrIdx] <= fifoData;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrIdx     <= '0;
      stored    <= '0;
      stopped   <= 1'b0;
      delayBusy <= 1'b0;
      delayLeft <= '0;
      haveStop  <= 1'b0;
      stopIdx   <= '0;
    end
    else
    begin
      if (runS && !runLast)
      begin
        stored    <= '0;
        stopped   <= 1'b0;
        haveStop  <= 1'b0;
        delayBusy <= 1'b0;
      end
      else if (fifoValid)
      begin
        wrIdx <= wrIdx + 1'b1;
        if (stored != CW'(2**DEPTH_LOG2))
        begin
          stored <= stored + 1'b1;
        end
        if (delayBusy)
        begin
          if (delayLeft <= 32'd1)
          begin
            delayBusy <= 1'b0;
            stopped   <= 1'b1;
          end
          delayLeft <= delayLeft - 1'b1;
        end
      end
      if (stopSync && delayEn && !delayBusy && !haveStop && runS)
      begin
        haveStop <= 1'b1;
        // records still queued in the fifo land ahead of the stop cycle
        stopIdx  <= wrIdx + DEPTH_LOG2'(fifoLevel);
        if (delayCount == '0)
        begin
          stopped <= 1'b1;
        end
        else
        begin
          delayBusy <= 1'b1;
          delayLeft <= delayCount;
        end
      end
    end
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic        apbWrite;
  logic        apbRead;
  logic [31:0] rdIndex;
  logic [DEPTH_LOG2-1:0] memIdx;
  logic [FW-1:0] rdRec;
  logic [31:0] next_prdata;
  logic        next_err;

  assign apbWrite = psel && penable && pwrite && pready;
  assign apbRead  = psel && !penable && !pwrite;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      delayEn    <= CTRL_RESET[CTRL_DELAY_EN_BIT];
      delayCount <= DELAY_RESET;
      rdIndex    <= '0;
    end
    else if (apbWrite)
    begin
      if (paddr == CTRL_OFFS)
      begin
        delayEn <= pwdata[CTRL_DELAY_EN_BIT];
      end
      else if (paddr == DELAY_OFFS)
      begin
        delayCount <= pwdata;
      end
      else if (paddr == RD_IDX_OFFS)
      begin
        rdIndex <= pwdata;
      end
    end
  end

  // signed index: 0 is newest (or stop cycle with delay), negatives older
  always_comb
  begin
    if (haveStop)
    begin
      memIdx = stopIdx + DEPTH_LOG2'(rdIndex);
    end
    else
    begin
      memIdx = wrIdx - 1'b1 + DEPTH_LOG2'(rdIndex);
    end
  end

  // read data is registered at the setup edge, so an index written in
  // the transfer just before already selects the word
  assign rdRec = traceMem[memIdx];

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    next_err    = 1'b0;
    if (paddr == CTRL_OFFS)
    begin
      next_prdata[CTRL_DELAY_EN_BIT] = delayEn;
    end
    else if (paddr == STATUS_OFFS)
    begin
      next_prdata[STAT_FULL_BIT]    = stored[DEPTH_LOG2];
      next_prdata[STAT_STOPPED_BIT] = stopped;
      next_prdata[STAT_TSOVF_BIT]   = stampOvf;
      next_prdata[STAT_RUN_BIT]     = runS;
      next_prdata[STAT_DLYBUSY_BIT] = delayBusy;
    end
    else if (paddr == DELAY_OFFS)
    begin
      next_prdata = delayCount;
    end
    else if (paddr == COUNT_OFFS)
    begin
      next_prdata = 32'(stored);
    end
    else if (paddr == RD_IDX_OFFS)
    begin
      next_prdata = rdIndex;
    end
    else if (paddr == RD_ADDR_OFFS)
    begin
      next_prdata = {8'h00, rdRec[RW-1:RW-24]};
    end
    else if (paddr == RD_DATA_OFFS)
    begin
      next_prdata = {16'h0000, rdRec[RW-25:RW-40]};
    end
    else if (paddr == RD_STATE_OFFS)
    begin
      next_prdata = {12'h000, rdRec[RW-41:0]};
    end
    else if (paddr == RD_TIME_OFFS)
    begin
      next_prdata = rdRec[FW-2:RW];
    end
    else if (paddr == RD_NUM_OFFS)
    begin
      next_prdata = {31'h0, rdRec[FW-1]};
    end
    else if (paddr == FIFO_LVL_OFFS)
    begin
      next_prdata = 32'(fifoLevel);
    end
    else
    begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata      <= '0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      traceActive <= 1'b0;
    end
    else
    begin
      traceActive <= runS && !stopped;
      pready      <= psel && !penable;
      if (psel && !penable)
      begin
        prdata  <= apbRead ? next_prdata : 32'h0000_0000;
        pslverr <= next_err;
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule

//--- verif/bctr_tb_pkg.sv
package bctr_tb_pkg;
  // record state word the target presents for bus cycle n
  function automatic logic [19:0] fState(input logic [7:0] n);
    logic       own;
    logic [2:0] cpu;
    logic [2:0] q;
    own = (n[3:1] == 3'h3);
    // the target presents fill counts up to seven; the record holds four
    q = (n[2:0] > 3'h4) ? 3'h4 : n[2:0];
    // target cpu stalls while the debugger holds the bus
    cpu = own ? 3'h0 : 3'(n % 6);
    return {n[0], n[1], 3'(n % 7), 2'(n % 3), n[2], cpu, q,
      ~own, n[3] ? n[3:0] : 4'h0, n[4]};
  endfunction
endpackage

//--- verif/bctr_target_model.sv
`timescale 1ns/100ps
module bctr_target_model
  import bctr_tb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        run,
  input  wire logic [7:0]  stopAt,
  output logic             programRun,
  output logic             busCycle,
  output logic      [23:0] targetAddress,
  output logic      [15:0] targetData,
  output logic             busWide,
  output logic             upper_byte_enable_n,
  output logic      [2:0]  bus_interface_state,
  output logic      [1:0]  busDirection,
  output logic             cycle_valid_n,
  output logic      [2:0]  cpuState,
  output logic      [2:0]  queue_fill_count,
  output logic             debugger_bus_own,
  output logic             eventFired,
  output logic      [3:0]  matched_point_id,
  output logic             outside_trigger_level,
  output logic             stopCondition
);
  logic [7:0]  n;
  logic        flip;
  logic [19:0] st;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      n    <= 8'h00;
      flip <= 1'b0;
    end
    else
    begin
      flip <= ~flip;
      n    <= run ? n + 8'h01 : 8'h00;
    end
  end
  assign st = fState(n);
  assign programRun = run;
  assign busCycle = run;
  // idle lines toggle so a stale sample can never pass for a fresh one
  assign {busWide, upper_byte_enable_n, bus_interface_state, busDirection,
    cycle_valid_n, cpuState} = run ? st[19:9] : {11{flip}};
  // raw fill count, above four on some cycles
  assign queue_fill_count = run ? n[2:0] : {3{flip}};
  assign debugger_bus_own = run & ~st[5];
  assign eventFired = run & n[3];
  assign matched_point_id = run ? n[3:0] : {4{flip}};
  assign outside_trigger_level = run ? st[0] : flip;
  assign targetAddress = run ? {16'h0001, n} : {24{flip}};
  assign targetData = run ? {n, ~n} : {16{flip}};
  assign stopCondition = run && (n == stopAt);
endmodule

//--- verif/bctr_checker.sv
`timescale 1ns/100ps
module bctr_checker (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        programRun,
  input wire logic        stopCondition,
  input wire logic        traceActive
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("ready missing after setup");
  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("ready outside access");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held too long");
  property p_refused;
    pready && paddr > 12'h028 |-> pslverr && prdata == 32'h0;
  endproperty
  a_refused: assert property (p_refused)
    else $error("unmapped access not refused");
  property p_mapped;
    pready && paddr <= 12'h028 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped)
    else $error("mapped access refused");
  property p_halt;
    !programRun [*4] |-> !traceActive;
  endproperty
  a_halt: assert property (p_halt)
    else $error("trace active while halted");
  property p_run;
    $rose(programRun) && !stopCondition
      ##1 (programRun && !stopCondition) [*5] |-> traceActive;
  endproperty
  a_run: assert property (p_run)
    else $error("trace idle while running");
  property p_cause;
    traceActive |-> $past(programRun, 3);
  endproperty
  a_cause: assert property (p_cause)
    else $error("trace active without run");
endmodule
bind bctr_recorder bctr_checker i_chk (.clock, .reset_n, .paddr, .psel,
  .penable, .prdata, .pready, .pslverr, .programRun, .stopCondition,
  .traceActive);

//--- verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import bctr_pkg::*;
  import bctr_tb_pkg::*;
  localparam logic [31:0] LOW = 32'h0000_0FFF;
  logic        clock = 1'b0;
  logic        reset_n, psel, penable, pwrite, pready, pslverr, run, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, tRec, t1;
  logic [7:0]  stopAt;
  logic        programRun, busCycle, busWide, upper_byte_enable_n;
  logic        cycle_valid_n, debugger_bus_own, eventFired, stopCondition;
  logic        outside_trigger_level, traceActive;
  logic [23:0] targetAddress;
  logic [15:0] targetData;
  logic [2:0]  bus_interface_state, cpuState, queue_fill_count;
  logic [1:0]  busDirection;
  logic [3:0]  matched_point_id;
  int          errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  always #10 clock = ~clock;
  bctr_recorder #(.DEPTH_LOG2(6), .FIFO_DEP(FIFO_DEPTH)) i_dut (.clock,
    .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .programRun, .busCycle, .targetAddress, .targetData, .busWide,
    .upper_byte_enable_n, .bus_interface_state, .busDirection,
    .cycle_valid_n, .cpuState, .queue_fill_count, .debugger_bus_own,
    .eventFired, .matched_point_id, .outside_trigger_level, .stopCondition,
    .traceActive);
  bctr_target_model i_tgt (.clock, .reset_n, .run, .stopAt, .programRun,
    .busCycle, .targetAddress, .targetData, .busWide, .upper_byte_enable_n,
    .bus_interface_state, .busDirection, .cycle_valid_n, .cpuState,
    .queue_fill_count, .debugger_bus_own, .eventFired, .matched_point_id,
    .outside_trigger_level, .stopCondition);
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic results();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic runFor(input int len);
    @(posedge clock);
    run <= 1'b1;
    repeat (len) @(posedge clock);
    run <= 1'b0;
    repeat (12) @(posedge clock);
  endtask
  task automatic rec(input int i, input logic [7:0] n);
    logic [31:0] e;
    e = {12'h000, fState(n)};
    apb(1'b1, RD_IDX_OFFS, 32'(i));
    apb(1'b0, RD_ADDR_OFFS, 32'h0);
    chk("addr", rd, {8'h00, 16'h0001, n});
    apb(1'b0, RD_DATA_OFFS, 32'h0);
    chk("data", rd, {16'h0000, n, ~n});
    apb(1'b0, RD_STATE_OFFS, 32'h0);
    chk("hi", rd & ~LOW, e & ~LOW);
    chk("lo", rd & LOW, e & LOW);
    apb(1'b0, RD_TIME_OFFS, 32'h0);
    tRec = rd;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      results();
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    {reset_n, psel, penable, pwrite, run} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    stopAt = 8'hFF;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    apb(1'b0, CTRL_OFFS, 32'h0);
    chk("ctrl", rd, CTRL_RESET);
    apb(1'b0, DELAY_OFFS, 32'h0);
    chk("delay", rd, DELAY_RESET);
    apb(1'b0, FIFO_LVL_OFFS, 32'h0);
    chk("level", rd, 32'h0);
    apb(1'b1, 12'h100, 32'hFFFF_FFFF);
    chk("werr", 32'(er), 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    chk("rerr", 32'(er), 32'h1);
    chk("rdat", rd, 32'h0);
    runFor(10);
    apb(1'b0, COUNT_OFFS, 32'h0);
    chk("count", rd, 32'hA);
    for (int k = 0; k < 10; k++)
    begin
      rec(-k, 8'(9 - k));
      if (k == 0)
        t1 = tRec;
      chk("time", tRec, t1 - 32'(k));
    end
    apb(1'b0, RD_NUM_OFFS, 32'h0);
    chk("ovf", 32'(rd[0]), 32'h0);
    runFor(100);
    apb(1'b0, COUNT_OFFS, 32'h0);
    chk("count", rd, 32'h40);
    apb(1'b0, STATUS_OFFS, 32'h0);
    chk("full", 32'(rd[STAT_FULL_BIT]), 32'h1);
    rec(0, 8'h63);
    chk("restart", tRec - t1, 32'h5A);
    t1 = tRec;
    rec(-63, 8'h24);
    chk("span", t1 - tRec, 32'h3F);
    apb(1'b1, DELAY_OFFS, 32'h5);
    apb(1'b1, CTRL_OFFS, 32'h1);
    stopAt <= 8'h14;
    runFor(40);
    apb(1'b0, STATUS_OFFS, 32'h0);
    chk("stopped", 32'(rd[STAT_STOPPED_BIT]), 32'h1);
    rec(0, 8'h14);
    rec(5, 8'h19);
    rec(-1, 8'h13);
    results();
  end
endmodule
